// ---- pkg/dcss_regs.svh ----
// register map, codes, reset values and timing for the drive command source select block
`ifndef DCSS_REGS_SVH
`define DCSS_REGS_SVH
`define DCSS_REG_RUN_CMD 16'h2501
`define DCSS_REG_FREQ_REF 16'h2502
`define DCSS_REG_FREQ_SRC 16'h2600
`define DCSS_REG_RUN_SRC 16'h2601
`define DCSS_REG_BACK_INHIBIT 16'h2602
`define DCSS_REG_STOP_METHOD 16'h2603
`define DCSS_REG_SEC_TYPE 16'h2604
`define DCSS_REG_DISP_UNIT 16'h2605
`define DCSS_REG_STATUS 16'h2610
`define DCSS_REG_OUT_FREQ 16'h2611
`define DCSS_FREQ_MAX 16'h9C40
`define DCSS_NODE_ADDR 8'h01
`define DCSS_BCAST_ADDR 8'h00
`define DCSS_FN_READ 8'h03
`define DCSS_FN_WRITE 8'h06
`define DCSS_EXC_FUNC 8'h01
`define DCSS_EXC_ADDR 8'h02
`define DCSS_EXC_VALUE 8'h03
`define DCSS_EXC_REFUSED 8'h04
`define DCSS_FSRC_KEYPAD 3'h0
`define DCSS_FSRC_ANALOG1 3'h1
`define DCSS_FSRC_UPDOWN 3'h2
`define DCSS_FSRC_SERIAL 3'h3
`define DCSS_FSRC_RES4 3'h4
`define DCSS_FSRC_RES5 3'h5
`define DCSS_FSRC_CLOCK 3'h6
`define DCSS_FSRC_ANALOG2 3'h7
`define DCSS_RSRC_KEYPAD 3'h0
`define DCSS_RSRC_TERMINAL 3'h1
`define DCSS_RSRC_SERIAL 3'h2
`define DCSS_RSRC_SEQUENCER 3'h3
`define DCSS_RSRC_CLOCK 3'h4
`define DCSS_STOP_DECEL 2'h0
`define DCSS_SEC_TYPE_RST 1'h1
`define DCSS_CLK_HZ 100000000
`define DCSS_BAUD 9600
`define DCSS_BIT_CYCLES (`DCSS_CLK_HZ / `DCSS_BAUD)
`define DCSS_GAP_BITS 35
`define DCSS_GAP_CYCLES (`DCSS_BIT_CYCLES * `DCSS_GAP_BITS)
`endif

// ---- pkg/dcss_pkg.sv ----
// types shared by the command source select block
package dcss_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TX, ST_DRAIN} dcss_state_t;
	typedef enum logic [2:0] {DISP_HZ, DISP_PCT, DISP_RPM, DISP_INT, DISP_DEC1, DISP_DEC2, DISP_DEC3} dcss_disp_t;
	typedef struct packed {
		logic rx_busy; logic [19:0] rx_cnt; logic [3:0] rx_bit; logic [7:0] rx_sh;
		logic rx_valid; logic rx_err; logic [19:0] gap_cnt; logic gap_armed; logic frame_end;
		logic tx_busy; logic [19:0] tx_cnt; logic [3:0] tx_bit; logic [9:0] tx_sh;
		logic tx_line; logic tx_oe_n;
	} dcss_uart_t;
	typedef struct packed {
		dcss_state_t st; logic [3:0] rx_cnt; logic rx_bad; logic [7:0][7:0] rx_buf;
		logic [15:0] crc; logic [5:0][7:0] rbuf; logic [2:0] rlen; logic [3:0] idx;
		logic tx_valid; logic [7:0] tx_data;
		logic [15:0] run_cmd; logic [15:0] freq_ref; logic [2:0] freq_src; logic [2:0] run_src;
		logic back_inhibit; logic [1:0] stop_method; logic sec_type; logic [15:0] disp_unit;
		logic kp_run; logic kp_back; logic run; logic back; logic [15:0] fref;
		logic [15:0] aux; logic aux_act; dcss_disp_t disp_class; logic [15:0] disp_scale;
	} dcss_main_t;
endpackage

// ---- pkg/dcss_byte_if.sv ----
// byte stream between the protocol engine and the serial line transceiver
`timescale 1ns/100ps
interface dcss_byte_if;
	logic rx_valid;
	logic rx_err;
	logic frame_end;
	logic [7:0] rx_data;
	logic tx_valid;
	logic tx_ready;
	logic tx_hold;
	logic [7:0] tx_data;
	modport link(output rx_valid, rx_err, frame_end, rx_data, tx_ready, input tx_valid, tx_hold, tx_data);
	modport proto(input rx_valid, rx_err, frame_end, rx_data, tx_ready, output tx_valid, tx_hold, tx_data);
endinterface

// ---- rtl/dcss_uart.sv ----
// 8N1 serial transceiver with end-of-frame silence detector
`timescale 1ns/100ps
`include "dcss_regs.svh"
module dcss_uart #(
	parameter int unsigned BIT_CYCLES = `DCSS_BIT_CYCLES,
	parameter int unsigned GAP_CYCLES = `DCSS_GAP_CYCLES
) (
	input wire logic clk_in, // system clock
	input wire logic rst_in, // synchronous reset
	input wire logic rx_pin_in, // receive line
	output logic tx_pin_out, // transmit line
	output logic tx_oe_n_out, // transmitter enable, low drives
	dcss_byte_if.link lnk // byte stream
);
	import dcss_pkg::*;
	localparam logic [19:0] BIT_LAST = 20'(BIT_CYCLES - 1);
	localparam logic [19:0] BIT_HALF = 20'(BIT_CYCLES / 2);
	localparam logic [19:0] GAP_LAST = 20'(GAP_CYCLES - 1);
	dcss_uart_t u_reg, u_next;

	always_comb begin
		u_next = u_reg;
		u_next.rx_valid = 1'b0;
		u_next.rx_err = 1'b0;
		u_next.frame_end = 1'b0;
		if (!u_reg.rx_busy) begin
			if (!rx_pin_in) begin
				u_next.rx_busy = 1'b1;
				u_next.rx_cnt = BIT_HALF;
				u_next.rx_bit = 4'h0;
			end
		end else if (u_reg.rx_cnt != 20'h00000) begin
			u_next.rx_cnt = u_reg.rx_cnt - 20'h00001;
		end else begin
			u_next.rx_cnt = BIT_LAST;
			u_next.rx_bit = u_reg.rx_bit + 4'h1;
			if (u_reg.rx_bit == 4'h0 && rx_pin_in) begin
				u_next.rx_busy = 1'b0; // start bit was a glitch
			end else if (u_reg.rx_bit == 4'h9) begin
				u_next.rx_busy = 1'b0;
				u_next.rx_valid = rx_pin_in;
				u_next.rx_err = !rx_pin_in;
				u_next.gap_armed = 1'b1;
			end else if (u_reg.rx_bit != 4'h0) begin
				u_next.rx_sh = {rx_pin_in, u_reg.rx_sh[7:1]};
			end
		end
		// silence after the last byte marks the end of a frame
		if (u_reg.rx_busy || !rx_pin_in) begin
			u_next.gap_cnt = 20'h00000;
		end else if (u_reg.gap_armed) begin
			if (u_reg.gap_cnt == GAP_LAST) begin
				u_next.frame_end = 1'b1;
				u_next.gap_armed = 1'b0;
				u_next.gap_cnt = 20'h00000;
			end else begin
				u_next.gap_cnt = u_reg.gap_cnt + 20'h00001;
			end
		end
		if (!u_reg.tx_busy) begin
			if (lnk.tx_valid) begin
				u_next.tx_busy = 1'b1;
				u_next.tx_sh = {1'b1, lnk.tx_data, 1'b0};
				u_next.tx_line = 1'b0;
				u_next.tx_cnt = BIT_LAST;
				u_next.tx_bit = 4'h0;
			end
		end else if (u_reg.tx_cnt != 20'h00000) begin
			u_next.tx_cnt = u_reg.tx_cnt - 20'h00001;
		end else if (u_reg.tx_bit == 4'h9) begin
			u_next.tx_busy = 1'b0;
			u_next.tx_line = 1'b1;
		end else begin
			u_next.tx_cnt = BIT_LAST;
			u_next.tx_bit = u_reg.tx_bit + 4'h1;
			u_next.tx_sh = {1'b1, u_reg.tx_sh[9:1]};
			u_next.tx_line = u_reg.tx_sh[1];
		end
		// hold keeps the driver on between bytes of one reply
		u_next.tx_oe_n = !(u_next.tx_busy || lnk.tx_hold);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			u_reg <= '0;
			u_reg.tx_line <= 1'b1;
			u_reg.tx_oe_n <= 1'b1;
		end else begin
			u_reg <= u_next;
		end
	end

	assign lnk.rx_valid = u_reg.rx_valid;
	assign lnk.rx_err = u_reg.rx_err;
	assign lnk.frame_end = u_reg.frame_end;
	assign lnk.rx_data = u_reg.rx_sh;
	assign lnk.tx_ready = !u_reg.tx_busy;
	assign tx_pin_out = u_reg.tx_line;
	assign tx_oe_n_out = u_reg.tx_oe_n;
endmodule

// ---- rtl/dcss_command_select.sv ----
// drive command front end: reference and run source select, serial register slave
`timescale 1ns/100ps
`include "dcss_regs.svh"
module dcss_command_select #(
	parameter int unsigned BIT_CYCLES = `DCSS_BIT_CYCLES,
	parameter int unsigned GAP_CYCLES = `DCSS_GAP_CYCLES
) (
	input wire logic SYS_CLK_IN, // 100 MHz clock
	input wire logic SYS_RST_IN, // synchronous reset, high
	input wire logic RS485_RX_IN, // serial receive line
	output logic RS485_TX_OUT, // serial transmit line
	output logic RS485_TX_OE_N_OUT, // line driver enable, low drives
	input wire logic [15:0] KEYPAD_FREQ_IN, // keypad reference, 0.01 Hz
	input wire logic [15:0] ANALOG_INPUT_PRIMARY_IN, // first analog reference
	input wire logic [15:0] ANALOG_INPUT_SECONDARY_IN, // second analog reference
	input wire logic [15:0] UPDOWN_FREQ_IN, // up/down terminal reference
	input wire logic [15:0] CLOCK_SCHED_FREQ_IN, // real-time clock reference
	input wire logic KEY_RUN_IN, // run key pulse
	input wire logic KEY_STOP_IN, // stop key pulse
	input wire logic DIRECTION_TOGGLE_KEY_IN, // direction key pulse
	input wire logic RUN_FORWARD_REQUEST_IN, // terminal forward contact
	input wire logic RUN_BACKWARD_REQUEST_IN, // terminal reverse contact
	input wire logic BUILT_IN_LOGIC_SEQUENCER_RUN_IN, // sequencer run
	input wire logic BUILT_IN_LOGIC_SEQUENCER_BACK_IN, // sequencer reverse
	input wire logic CLOCK_SCHED_RUN_IN, // clock schedule run
	input wire logic CLOCK_SCHED_BACK_IN, // clock schedule reverse
	output logic RUN_OUT, // drive running
	output logic REVERSE_OUT, // running in reverse
	output logic [1:0] STOP_METHOD_OUT, // stop method code
	output logic [15:0] FREQ_REF_OUT, // selected reference, 0.01 Hz
	output logic [15:0] AUX_FREQ_OUT, // auxiliary reference
	output logic AUX_ACTIVE_OUT, // auxiliary reference in use
	output logic SECONDARY_CURRENT_MODE_OUT, // 1: second input is 4-20 mA
	output dcss_pkg::dcss_disp_t DISP_CLASS_OUT, // display unit class
	output logic [15:0] DISP_SCALE_OUT // full-scale digits of scaled units
);
	import dcss_pkg::*;
	dcss_main_t m_reg, m_next;
	dcss_byte_if lnk ();

	dcss_uart #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_uart (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.rx_pin_in(RS485_RX_IN),
		.tx_pin_out(RS485_TX_OUT),
		.tx_oe_n_out(RS485_TX_OE_N_OUT),
		.lnk(lnk.link)
	);

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
		end
		return x;
	endfunction

	function automatic logic disp_ok(input logic [15:0] v);
		return (v <= 16'h0002) || (v >= 16'h0028 && v <= 16'h270F) || (v >= 16'h2711 && v <= 16'h4E1F)
			|| (v >= 16'h4E21 && v <= 16'h752F) || (v >= 16'h7531 && v <= 16'h9C3F);
	endfunction

	logic [15:0] addr_w;
	logic [15:0] val_w;
	logic [15:0] rd_w;
	logic [7:0] exc;
	logic [7:0] fn;
	logic [7:0] out_byte;
	logic want_run;
	logic want_back;

	always_comb begin
		m_next = m_reg;
		m_next.tx_valid = 1'b0;
		addr_w = {m_reg.rx_buf[2], m_reg.rx_buf[3]};
		val_w = {m_reg.rx_buf[4], m_reg.rx_buf[5]};
		fn = m_reg.rx_buf[1];
		rd_w = 16'h0000;
		exc = 8'h00;
		out_byte = 8'h00;
		want_run = 1'b0;
		want_back = 1'b0;
		unique case (m_reg.st)
			ST_IDLE: begin
				if (lnk.rx_valid) begin
					if (m_reg.rx_cnt < 4'h8) begin
						m_next.rx_buf[m_reg.rx_cnt[2:0]] = lnk.rx_data;
						m_next.crc = crc16(m_reg.crc, lnk.rx_data);
						m_next.rx_cnt = m_reg.rx_cnt + 4'h1;
					end else begin
						m_next.rx_bad = 1'b1;
					end
				end
				if (lnk.rx_err) begin
					m_next.rx_bad = 1'b1;
				end
				if (lnk.frame_end) begin
					m_next.rx_cnt = 4'h0;
					m_next.rx_bad = 1'b0;
					m_next.crc = 16'hFFFF;
					// residue over data plus appended crc is zero for a good frame
					if (!m_reg.rx_bad && m_reg.rx_cnt == 4'h8 && m_reg.crc == 16'h0000
						&& (m_reg.rx_buf[0] == `DCSS_NODE_ADDR || m_reg.rx_buf[0] == `DCSS_BCAST_ADDR)) begin
						m_next.st = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				if (fn == `DCSS_FN_READ) begin
					if (val_w != 16'h0001) begin
						exc = `DCSS_EXC_VALUE;
					end else begin
						case (addr_w)
							`DCSS_REG_RUN_CMD: rd_w = m_reg.run_cmd;
							`DCSS_REG_FREQ_REF: rd_w = m_reg.freq_ref;
							`DCSS_REG_FREQ_SRC: rd_w = {13'h0000, m_reg.freq_src};
							`DCSS_REG_RUN_SRC: rd_w = {13'h0000, m_reg.run_src};
							`DCSS_REG_BACK_INHIBIT: rd_w = {15'h0000, m_reg.back_inhibit};
							`DCSS_REG_STOP_METHOD: rd_w = {14'h0000, m_reg.stop_method};
							`DCSS_REG_SEC_TYPE: rd_w = {15'h0000, m_reg.sec_type};
							`DCSS_REG_DISP_UNIT: rd_w = m_reg.disp_unit;
							`DCSS_REG_STATUS: rd_w = {14'h0000, m_reg.back, m_reg.run};
							`DCSS_REG_OUT_FREQ: rd_w = m_reg.fref;
							default: exc = `DCSS_EXC_ADDR;
						endcase
					end
				end else if (fn == `DCSS_FN_WRITE) begin
					case (addr_w)
						`DCSS_REG_RUN_CMD: m_next.run_cmd = val_w;
						`DCSS_REG_FREQ_REF: begin
							if (m_reg.freq_src != `DCSS_FSRC_SERIAL) begin
								exc = `DCSS_EXC_REFUSED;
							end else if (val_w > `DCSS_FREQ_MAX) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.freq_ref = val_w;
							end
						end
						`DCSS_REG_FREQ_SRC: begin
							if (val_w > 16'h0007 || val_w[2:0] == `DCSS_FSRC_RES4 || val_w[2:0] == `DCSS_FSRC_RES5) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.freq_src = val_w[2:0];
							end
						end
						`DCSS_REG_RUN_SRC: begin
							if (val_w > 16'h0004) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.run_src = val_w[2:0];
							end
						end
						`DCSS_REG_BACK_INHIBIT: begin
							if (val_w > 16'h0001) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.back_inhibit = val_w[0];
							end
						end
						`DCSS_REG_STOP_METHOD: begin
							if (val_w > 16'h0003) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.stop_method = val_w[1:0];
							end
						end
						`DCSS_REG_SEC_TYPE: begin
							if (val_w > 16'h0001) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.sec_type = val_w[0];
							end
						end
						`DCSS_REG_DISP_UNIT: begin
							if (!disp_ok(val_w)) begin
								exc = `DCSS_EXC_VALUE;
							end else begin
								m_next.disp_unit = val_w;
							end
						end
						default: exc = `DCSS_EXC_ADDR;
					endcase
				end else begin
					exc = `DCSS_EXC_FUNC;
				end
				if (exc != 8'h00) begin
					m_next.rbuf[0] = m_reg.rx_buf[0];
					m_next.rbuf[1] = fn | 8'h80;
					m_next.rbuf[2] = exc;
					m_next.rlen = 3'h3;
				end else if (fn == `DCSS_FN_READ) begin
					m_next.rbuf[0] = m_reg.rx_buf[0];
					m_next.rbuf[1] = fn;
					m_next.rbuf[2] = 8'h02;
					m_next.rbuf[3] = rd_w[15:8];
					m_next.rbuf[4] = rd_w[7:0];
					m_next.rlen = 3'h5;
				end else begin
					m_next.rbuf = m_reg.rx_buf[5:0];
					m_next.rlen = 3'h6;
				end
				m_next.idx = 4'h0;
				m_next.crc = 16'hFFFF;
				// broadcast writes act but never answer
				m_next.st = (m_reg.rx_buf[0] == `DCSS_BCAST_ADDR) ? ST_IDLE : ST_TX;
			end
			ST_TX: begin
				if (!m_reg.tx_valid && lnk.tx_ready) begin
					if (m_reg.idx == {1'b0, m_reg.rlen} + 4'h2) begin
						m_next.st = ST_DRAIN;
					end else begin
						if (m_reg.idx == {1'b0, m_reg.rlen}) begin
							out_byte = m_reg.crc[7:0];
						end else if (m_reg.idx == {1'b0, m_reg.rlen} + 4'h1) begin
							out_byte = m_reg.crc[15:8];
						end else begin
							out_byte = m_reg.rbuf[m_reg.idx[2:0]];
							m_next.crc = crc16(m_reg.crc, out_byte);
						end
						m_next.tx_valid = 1'b1;
						m_next.tx_data = out_byte;
						m_next.idx = m_reg.idx + 4'h1;
					end
				end
			end
			ST_DRAIN: begin
				if (lnk.tx_ready) begin
					m_next.st = ST_IDLE;
					m_next.crc = 16'hFFFF; // reply checksum must not seed the next frame
				end
			end
		endcase

		// keypad latch is dropped when another source takes over so it cannot restart later
		if (m_reg.run_src != `DCSS_RSRC_KEYPAD) begin
			m_next.kp_run = 1'b0;
		end else if (KEY_STOP_IN) begin
			m_next.kp_run = 1'b0;
		end else if (KEY_RUN_IN && !m_reg.kp_run) begin
			m_next.kp_run = 1'b1;
			m_next.kp_back = 1'b0;
		end
		if (m_reg.run_src == `DCSS_RSRC_KEYPAD && DIRECTION_TOGGLE_KEY_IN && !m_reg.back_inhibit) begin
			m_next.kp_back = !m_next.kp_back;
		end
		if (m_reg.back_inhibit) begin
			m_next.kp_back = 1'b0;
		end
		case (m_reg.run_src)
			`DCSS_RSRC_KEYPAD: begin
				want_run = m_reg.kp_run;
				want_back = m_reg.kp_back;
			end
			`DCSS_RSRC_TERMINAL: begin
				want_run = RUN_FORWARD_REQUEST_IN || RUN_BACKWARD_REQUEST_IN;
				want_back = RUN_BACKWARD_REQUEST_IN && !RUN_FORWARD_REQUEST_IN;
			end
			`DCSS_RSRC_SERIAL: begin
				want_run = m_reg.run_cmd[0] || m_reg.run_cmd[1];
				want_back = m_reg.run_cmd[1];
			end
			`DCSS_RSRC_SEQUENCER: begin
				want_run = BUILT_IN_LOGIC_SEQUENCER_RUN_IN;
				want_back = BUILT_IN_LOGIC_SEQUENCER_BACK_IN;
			end
			`DCSS_RSRC_CLOCK: begin
				want_run = CLOCK_SCHED_RUN_IN;
				want_back = CLOCK_SCHED_BACK_IN;
			end
			default: begin
				want_run = 1'b0;
				want_back = 1'b0;
			end
		endcase
		m_next.run = want_run && !(want_back && m_reg.back_inhibit);
		m_next.back = want_run && want_back && !m_reg.back_inhibit;

		case (m_reg.freq_src)
			`DCSS_FSRC_KEYPAD: m_next.fref = KEYPAD_FREQ_IN;
			`DCSS_FSRC_ANALOG1: m_next.fref = ANALOG_INPUT_PRIMARY_IN;
			`DCSS_FSRC_UPDOWN: m_next.fref = UPDOWN_FREQ_IN;
			`DCSS_FSRC_SERIAL: m_next.fref = m_reg.freq_ref;
			`DCSS_FSRC_CLOCK: m_next.fref = CLOCK_SCHED_FREQ_IN;
			`DCSS_FSRC_ANALOG2: m_next.fref = ANALOG_INPUT_SECONDARY_IN;
			default: m_next.fref = 16'h0000;
		endcase
		m_next.aux = ANALOG_INPUT_SECONDARY_IN;
		m_next.aux_act = (m_reg.freq_src == `DCSS_FSRC_ANALOG1);

		// register holds only accepted codes, so reserved ranges never reach here
		if (m_reg.disp_unit == 16'h0000) begin
			m_next.disp_class = DISP_HZ;
			m_next.disp_scale = 16'h0000;
		end else if (m_reg.disp_unit == 16'h0001) begin
			m_next.disp_class = DISP_PCT;
			m_next.disp_scale = 16'h0000;
		end else if (m_reg.disp_unit == 16'h0002) begin
			m_next.disp_class = DISP_RPM;
			m_next.disp_scale = 16'h0000;
		end else if (m_reg.disp_unit <= 16'h270F) begin
			m_next.disp_class = DISP_INT;
			m_next.disp_scale = m_reg.disp_unit;
		end else if (m_reg.disp_unit <= 16'h4E1F) begin
			m_next.disp_class = DISP_DEC1;
			m_next.disp_scale = m_reg.disp_unit - 16'h2710;
		end else if (m_reg.disp_unit <= 16'h752F) begin
			m_next.disp_class = DISP_DEC2;
			m_next.disp_scale = m_reg.disp_unit - 16'h4E20;
		end else begin
			m_next.disp_class = DISP_DEC3;
			m_next.disp_scale = m_reg.disp_unit - 16'h7530;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			m_reg <= '0;
			m_reg.st <= ST_IDLE;
			m_reg.crc <= 16'hFFFF;
			m_reg.freq_src <= `DCSS_FSRC_KEYPAD;
			m_reg.run_src <= `DCSS_RSRC_KEYPAD;
			m_reg.stop_method <= `DCSS_STOP_DECEL;
			m_reg.sec_type <= `DCSS_SEC_TYPE_RST;
			m_reg.disp_class <= DISP_HZ;
		end else begin
			m_reg <= m_next;
		end
	end

	assign lnk.tx_valid = m_reg.tx_valid;
	assign lnk.tx_data = m_reg.tx_data;
	assign lnk.tx_hold = (m_reg.st == ST_TX);
	assign RUN_OUT = m_reg.run;
	assign REVERSE_OUT = m_reg.back;
	assign STOP_METHOD_OUT = m_reg.stop_method;
	assign FREQ_REF_OUT = m_reg.fref;
	assign AUX_FREQ_OUT = m_reg.aux;
	assign AUX_ACTIVE_OUT = m_reg.aux_act;
	assign SECONDARY_CURRENT_MODE_OUT = m_reg.sec_type;
	assign DISP_CLASS_OUT = m_reg.disp_class;
	assign DISP_SCALE_OUT = m_reg.disp_scale;
endmodule

// ---- dv/dcss_command_select_checker.sv ----
// port assertions for the command source select block
`timescale 1ns/100ps
module dcss_command_select_checker import dcss_pkg::*; #(
	parameter int unsigned BIT_CYCLES = 16,
	parameter int unsigned GAP_CYCLES = 560
) (
	input wire logic SYS_CLK_IN, // clock
	input wire logic SYS_RST_IN, // reset
	input wire logic RS485_RX_IN, // rx line
	input wire logic RS485_TX_OUT, // tx line
	input wire logic RS485_TX_OE_N_OUT, // tx enable
	input wire logic [15:0] KEYPAD_FREQ_IN, // keypad ref
	input wire logic [15:0] ANALOG_INPUT_PRIMARY_IN, // analog 1
	input wire logic [15:0] ANALOG_INPUT_SECONDARY_IN, // analog 2
	input wire logic RUN_OUT, // running
	input wire logic REVERSE_OUT, // reverse
	input wire logic [1:0] STOP_METHOD_OUT, // stop method
	input wire logic [15:0] FREQ_REF_OUT, // reference
	input wire logic [15:0] AUX_FREQ_OUT, // aux reference
	input wire logic AUX_ACTIVE_OUT, // aux in use
	input wire logic SECONDARY_CURRENT_MODE_OUT, // input type
	input wire dcss_pkg::dcss_disp_t DISP_CLASS_OUT, // unit class
	input wire logic [15:0] DISP_SCALE_OUT // unit scale
);
	import dcss_pkg::*;
	logic [19:0] idle_cnt;
	logic [19:0] tx_run;
	logic tx_prev;
	// saturating: a long idle line must not wrap back under the gap
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN || !RS485_RX_IN) idle_cnt <= 20'h0;
		else if (idle_cnt != 20'hFFFFF) idle_cnt <= idle_cnt + 20'h1;
		tx_prev <= RS485_TX_OUT;
		if (SYS_RST_IN || RS485_TX_OUT != tx_prev) tx_run <= 20'h0;
		else if (tx_run != 20'hFFFFF) tx_run <= tx_run + 20'h1;
	end
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	property p_sil; $fell(RS485_TX_OE_N_OUT) |-> idle_cnt >= GAP_CYCLES; endproperty
	a_sil: assert property (p_sil) else $error("reply before frame gap");
	property p_start; $fell(RS485_TX_OE_N_OUT) |=> !RS485_TX_OUT; endproperty
	a_start: assert property (p_start) else $error("enable without start bit");
	property p_bit; RS485_TX_OUT != tx_prev |-> tx_run >= BIT_CYCLES - 1; endproperty
	a_bit: assert property (p_bit) else $error("tx bit too short");
	property p_rst; $fell(SYS_RST_IN) |-> SECONDARY_CURRENT_MODE_OUT && STOP_METHOD_OUT == 2'h0 && !RUN_OUT; endproperty
	a_rst: assert property (p_rst) else $error("bad reset outputs");
	property p_kp; $fell(SYS_RST_IN) |=> FREQ_REF_OUT == $past(KEYPAD_FREQ_IN); endproperty
	a_kp: assert property (p_kp) else $error("keypad not default source");
	property p_aux; !$past(SYS_RST_IN) |-> AUX_FREQ_OUT == $past(ANALOG_INPUT_SECONDARY_IN); endproperty
	a_aux: assert property (p_aux) else $error("aux not second input");
	property p_prim; AUX_ACTIVE_OUT && $past(AUX_ACTIVE_OUT) |-> FREQ_REF_OUT == $past(ANALOG_INPUT_PRIMARY_IN); endproperty
	a_prim: assert property (p_prim) else $error("master not first input");
	property p_back; REVERSE_OUT |-> RUN_OUT; endproperty
	a_back: assert property (p_back) else $error("reverse while stopped");
	property p_unit; DISP_CLASS_OUT < DISP_INT |-> DISP_SCALE_OUT == 16'h0000; endproperty
	a_unit: assert property (p_unit) else $error("scale on plain unit");
endmodule
bind dcss_command_select dcss_command_select_checker #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES))
	dcss_command_select_checker_i (.*);

// ---- dv/dcss_master.sv ----
// serial link master model on the block's receive line
`timescale 1ns/100ps
module dcss_master #(
	parameter int BIT = 8
) (
	input wire logic clk_in, // clock
	input wire logic line_in, // block tx line
	output logic line_out // block rx line
);
	logic [7:0] rq[$];
	initial line_out = 1'b1;
	function automatic logic [15:0] crc16(logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	// 8N1, lsb first, idle high
	task automatic put(logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			line_out = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT) @(negedge clk_in);
		end
	endtask
	// short wait between reply bytes keeps the run brief
	task automatic get();
		int t;
		logic [7:0] b;
		rq.delete();
		forever begin
			t = 0;
			while (line_in === 1'b1 && t < (rq.size() ? 6 * BIT : 100 * BIT)) begin
				@(negedge clk_in);
				t++;
			end
			if (line_in !== 1'b0) return;
			repeat (BIT / 2) @(negedge clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(negedge clk_in);
				b[i] = line_in;
			end
			repeat (BIT) @(negedge clk_in);
			rq.push_back(b);
		end
	endtask
	// crc appended low byte first; bad flips its lowest bit
	task automatic req(logic [7:0] node, logic [7:0] fn, logic [15:0] a, logic [15:0] v, logic bad);
		logic [7:0] q[$];
		logic [15:0] c;
		q = {node, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
		c = crc16(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) put(q[i]);
		get();
	endtask
endmodule

// ---- dv/test_drive_command_source_select.sv ----
// testbench for the command source select block
`timescale 1ns/100ps
module test_drive_command_source_select;
	import dcss_pkg::*;
	localparam int BITC = 8;
	logic clk, rst, rx, tx, oe_n, k_run, k_stop, k_dir, t_fore, t_back, s_run, s_back, c_run, c_back;
	logic run, back, aux_act, cur;
	logic [1:0] stop_m;
	logic [15:0] fref, aux, scale;
	dcss_disp_t dclass;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] sv [8] = '{16'h1111, 16'h2222, 16'h4444, 16'h0000, 16'h0000, 16'h0000, 16'h5555, 16'h3333};
	dcss_command_select #(.BIT_CYCLES(BITC), .GAP_CYCLES(35 * BITC)) dcss_command_select_i (
		.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .RS485_RX_IN(rx), .RS485_TX_OUT(tx), .RS485_TX_OE_N_OUT(oe_n),
		.KEYPAD_FREQ_IN(sv[0]), .ANALOG_INPUT_PRIMARY_IN(sv[1]), .ANALOG_INPUT_SECONDARY_IN(sv[7]),
		.UPDOWN_FREQ_IN(sv[2]), .CLOCK_SCHED_FREQ_IN(sv[6]), .KEY_RUN_IN(k_run), .KEY_STOP_IN(k_stop),
		.DIRECTION_TOGGLE_KEY_IN(k_dir), .RUN_FORWARD_REQUEST_IN(t_fore), .RUN_BACKWARD_REQUEST_IN(t_back),
		.BUILT_IN_LOGIC_SEQUENCER_RUN_IN(s_run), .BUILT_IN_LOGIC_SEQUENCER_BACK_IN(s_back),
		.CLOCK_SCHED_RUN_IN(c_run), .CLOCK_SCHED_BACK_IN(c_back), .RUN_OUT(run), .REVERSE_OUT(back),
		.STOP_METHOD_OUT(stop_m), .FREQ_REF_OUT(fref), .AUX_FREQ_OUT(aux), .AUX_ACTIVE_OUT(aux_act),
		.SECONDARY_CURRENT_MODE_OUT(cur), .DISP_CLASS_OUT(dclass), .DISP_SCALE_OUT(scale));
	dcss_master #(.BIT(BITC)) dcss_master_i (.clk_in(clk), .line_in(tx), .line_out(rx));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [15:0] v, logic [7:0] fn);
		dcss_master_i.req(8'h01, 8'h06, a, v, 1'b0);
		chk("reply function", dcss_master_i.rq.size() > 1 ? dcss_master_i.rq[1] : 8'hFF, fn);
	endtask
	task automatic key(int w);
		{k_run, k_stop, k_dir} = 3'b100 >> w;
		@(negedge clk);
		{k_run, k_stop, k_dir} = 3'b000;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_fsrc();
		for (int s = 0; s < 8; s++) begin
			wr(16'h2600, 16'(s), (s == 4 || s == 5) ? 8'h86 : 8'h06);
			chk("freq", fref, sv[s]);
			chk("aux active", aux_act, {15'h0, s == 1});
		end
	endtask
	task automatic t_sfreq();
		wr(16'h2502, 16'h03E8, 8'h86);
		chk("exception", dcss_master_i.rq[2], 16'h0004);
		wr(16'h2600, 16'h0003, 8'h06);
		wr(16'h2502, 16'h03E8, 8'h06);
		chk("freq", fref, 16'h03E8);
		wr(16'h2502, 16'h9C41, 8'h86);
		chk("freq", fref, 16'h03E8);
		wr(16'h2502, 16'h9C40, 8'h06);
		dcss_master_i.req(8'h01, 8'h06, 16'h2502, 16'h0BB8, 1'b1);
		chk("replies", 16'(dcss_master_i.rq.size()), 16'h0000);
		dcss_master_i.req(8'h02, 8'h06, 16'h2502, 16'h0BB8, 1'b0);
		chk("freq", fref, 16'h9C40);
		dcss_master_i.req(8'h01, 8'h03, 16'h2502, 16'h0001, 1'b0);
		chk("read", {dcss_master_i.rq[3], dcss_master_i.rq[4]}, 16'h9C40);
	endtask
	task automatic t_srun();
		wr(16'h2601, 16'h0002, 8'h06);
		wr(16'h2501, 16'h0001, 8'h06);
		chk("run", {run, back}, 16'h0002);
		wr(16'h2501, 16'h0002, 8'h06);
		chk("run", {run, back}, 16'h0003);
		dcss_master_i.req(8'h01, 8'h03, 16'h2610, 16'h0001, 1'b0);
		chk("status", dcss_master_i.rq[4], 16'h0003);
		wr(16'h2602, 16'h0001, 8'h06);
		chk("run", {run, back}, 16'h0000);
		wr(16'h2602, 16'h0000, 8'h06);
		wr(16'h2603, 16'h0001, 8'h06);
		chk("stop method", stop_m, 16'h0001);
		dcss_master_i.req(8'h00, 8'h06, 16'h2501, 16'h0000, 1'b0);
		chk("run", {run, back}, 16'h0000);
	endtask
	task automatic t_keypad();
		wr(16'h2601, 16'h0000, 8'h06);
		key(0);
		chk("run", {run, back}, 16'h0002);
		key(2);
		chk("run", {run, back}, 16'h0003);
		key(1);
		chk("run", {run, back}, 16'h0000);
	endtask
	task automatic t_term();
		for (int s = 1; s < 5; s++) begin
			if (s == 2) continue;
			wr(16'h2601, 16'(s), 8'h06);
			for (int j = 0; j < 3; j++) begin
				// sequencer and clock reverse only while their run input stands as well
				{t_fore, t_back, s_run, s_back, c_run, c_back} = (j == 0 ? 6'h2 : j == 1 ? {4'h0, s != 1, 1'b1} : 6'h0)
					<< (s == 1 ? 4 : s == 3 ? 2 : 0);
				repeat (3) @(negedge clk);
				chk("run", {run, back}, j == 0 ? 16'h0002 : j == 1 ? 16'h0003 : 16'h0000);
			end
		end
	endtask
	task automatic t_unit();
		logic [15:0] code [8] = '{16'h0, 16'h1, 16'h2, 16'h28, 16'h270F, 16'h2711, 16'h752F, 16'h9C3F};
		dcss_disp_t cl [8] = '{DISP_HZ, DISP_PCT, DISP_RPM, DISP_INT, DISP_INT, DISP_DEC1, DISP_DEC2, DISP_DEC3};
		logic [15:0] sc [8] = '{16'h0, 16'h0, 16'h0, 16'h28, 16'h270F, 16'h1, 16'h270F, 16'h270F};
		for (int i = 0; i < 8; i++) begin
			wr(16'h2605, code[i], 8'h06);
			chk("unit class", dclass, cl[i]);
			chk("unit scale", scale, sc[i]);
		end
		wr(16'h2605, 16'h0003, 8'h86);
		wr(16'h2604, 16'h0000, 8'h06);
		chk("input type", cur, 16'h0000);
	endtask
	initial begin
		rst = 1'b1;
		{k_run, k_stop, k_dir, t_fore, t_back, s_run, s_back, c_run, c_back} = 9'h000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk("freq", fref, sv[0]);
		chk("input type", cur, 16'h0001);
		t_fsrc();
		t_sfreq();
		t_srun();
		t_keypad();
		t_term();
		t_unit();
		finish_test();
	end
endmodule
